// >>> inc/i2c_flags_pkg.sv
// Purpose: shared constants for the i2c event and error flag block
// Assumes: 32-bit classic wishbone, byte addresses, one register per word
// Notes: offsets and the control/second status layouts are local choices
package i2c_flags_pkg;
   localparam int REG_W = 16;
   localparam int DATA_W = 8;
   localparam int ADR_W = 8;
   // =======================================================
   // register byte offsets
   localparam logic [7:0] OFF_STATUS_ONE = 8'h00;
   localparam logic [7:0] OFF_CONTROL_ONE = 8'h04;
   localparam logic [7:0] OFF_DATA_HOLD = 8'h08;
   localparam logic [7:0] OFF_STATUS_TWO = 8'h0C;
   // =======================================================
   // first status register fields
   localparam int B_START = 0;
   localparam int B_ADDR = 1;
   localparam int B_BYTE_DONE = 2;
   localparam int B_TEN_BIT = 3;
   localparam int B_STOP = 4;
   localparam int B_RX_FULL = 6;
   localparam int B_TX_EMPTY = 7;
   localparam int B_BUS_ERR = 8;
   localparam int B_ARB_LOST = 9;
   localparam int B_ACK_FAIL = 10;
   localparam int B_OVERRUN = 11;
   localparam int B_CHK_ERR = 12;
   // =======================================================
   // control and second status fields
   localparam int C_MODULE_ON = 0;
   localparam int C_NO_HOLD = 7;
   localparam int S2_MASTER = 0;
   localparam int S2_TX = 2;
   // =======================================================
   // reset values
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// >>> hdl/i2c_line_watch.sv
// Purpose: synchronise scl/sda and report start and stop conditions
// Assumes: pins are asynchronous to clk_i and much slower than it
// Notes: detection compares the second synchroniser stage with its one-cycle delayed copy
`timescale 1ns/1ps
module i2c_line_watch (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic start_o,
   output logic stop_o
);
   logic [1:0] scl_s_q;
   logic [1:0] sda_s_q;
   logic scl_q;
   logic sda_q;

   // =======================================================
   // two-stage synchronisers; idle bus is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_q <= scl_s_q[1];
         sda_q <= sda_s_q[1];
      end
   end

   // =======================================================
   // sda edge while scl stays high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_o <= 1'b0;
         stop_o <= 1'b0;
      end else begin
         start_o <= scl_q && scl_s_q[1] && sda_q && !sda_s_q[1];
         stop_o <= scl_q && scl_s_q[1] && !sda_q && sda_s_q[1];
      end
   end
endmodule

// >>> hdl/i2c_status_flags.sv
// Purpose: event and error flags of the first status register, wishbone slave
// Assumes: the byte engine gives same-clock one-cycle event pulses
// Notes: ack comes one cycle after the request; flag sets win over clears
`timescale 1ns/1ps
module i2c_status_flags (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic master_i,
   input wire logic tx_mode_i,
   input wire logic byte_active_i,
   input wire logic start_gen_i,
   input wire logic addr_sent_i,
   input wire logic hdr10_sent_i,
   input wire logic addr_match_i,
   input wire logic tx_load_i,
   input wire logic byte_tx_done_i,
   input wire logic byte_rx_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic ack_miss_i,
   input wire logic arb_lost_i,
   input wire logic pec_bad_i,
   output logic module_on_o,
   output logic no_clock_hold_o,
   output logic [7:0] tx_byte_o,
   output logic hold_clock_o,
   output logic pec_nak_o
);
   logic [15:0] ctl_q;
   logic [15:0] flags_q;
   logic [15:0] status_one;
   logic [7:0] dh_q;
   logic armed_q;
   logic slave_acked_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic pec_nak_q;
   logic line_start;
   logic line_stop;
   logic acc;
   logic wr_st1, wr_ctl, wr_dh, rd_st1, rd_st2, rd_dh;
   logic on;
   logic nohold;
   logic tx_underrun;
   logic rx_overrun;
   logic rx_stall;
   logic tx_stall;

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = adr[7:2] == off[7:2];
   endfunction

   i2c_line_watch u_watch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .start_o(line_start),
      .stop_o(line_stop)
   );

   // =======================================================
   // wishbone access decode, one access per request
   assign acc = cyc_i && stb_i && !ack_q;
   assign wr_st1 = acc && we_i && hit(adr_i, i2c_flags_pkg::OFF_STATUS_ONE);
   assign wr_ctl = acc && we_i && hit(adr_i, i2c_flags_pkg::OFF_CONTROL_ONE);
   assign wr_dh = acc && we_i && sel_i[0] && hit(adr_i, i2c_flags_pkg::OFF_DATA_HOLD);
   assign rd_st1 = acc && !we_i && hit(adr_i, i2c_flags_pkg::OFF_STATUS_ONE);
   assign rd_st2 = acc && !we_i && hit(adr_i, i2c_flags_pkg::OFF_STATUS_TWO);
   assign rd_dh = acc && !we_i && hit(adr_i, i2c_flags_pkg::OFF_DATA_HOLD);
   assign on = ctl_q[i2c_flags_pkg::C_MODULE_ON];
   assign nohold = ctl_q[i2c_flags_pkg::C_NO_HOLD];
   assign tx_stall = byte_tx_done_i && flags_q[i2c_flags_pkg::B_TX_EMPTY];
   assign rx_stall = byte_rx_i && flags_q[i2c_flags_pkg::B_RX_FULL];
   assign tx_underrun = tx_stall && nohold;
   assign rx_overrun = rx_stall && nohold;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q <= i2c_flags_pkg::CONTROL_RESET;
      end else if (wr_ctl) begin
         if (sel_i[0]) begin
            ctl_q[7:0] <= dat_i[7:0];
         end
         if (sel_i[1]) begin
            ctl_q[15:8] <= dat_i[15:8];
         end
      end
   end

   // =======================================================
   // status one read arms the two-step clear sequences
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_q <= 1'b0;
      end else if (acc) begin
         armed_q <= rd_st1;
      end
   end

   // =======================================================
   // data holding register; old byte stays put so an underrun resends it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dh_q <= i2c_flags_pkg::DATA_RESET;
      end else if (wr_dh) begin
         dh_q <= dat_i[7:0];
      end else if (byte_rx_i && on && !rx_stall) begin
         dh_q <= rx_byte_i;
      end
   end

   // slave stop only counts after this device acknowledged its address
   always_ff @(posedge clk_i) begin
      if (rst_i || !on) begin
         slave_acked_q <= 1'b0;
      end else if (!master_i && addr_match_i) begin
         slave_acked_q <= 1'b1;
      end else if (line_stop || line_start) begin
         slave_acked_q <= 1'b0;
      end
   end

   // =======================================================
   // flags: clears first, sets last so a same-cycle event is kept
   always_ff @(posedge clk_i) begin
      if (rst_i || !on) begin
         flags_q <= i2c_flags_pkg::STATUS_RESET;
      end else begin
         if (wr_st1 && sel_i[1]) begin
            // write 0 clears, write 1
            flags_q[i2c_flags_pkg::B_CHK_ERR] <= flags_q[i2c_flags_pkg::B_CHK_ERR] && dat_i[12];
            flags_q[i2c_flags_pkg::B_OVERRUN] <= flags_q[i2c_flags_pkg::B_OVERRUN] && dat_i[11];
            flags_q[i2c_flags_pkg::B_ACK_FAIL] <= flags_q[i2c_flags_pkg::B_ACK_FAIL] && dat_i[10];
            flags_q[i2c_flags_pkg::B_ARB_LOST] <= flags_q[i2c_flags_pkg::B_ARB_LOST] && dat_i[9];
            flags_q[i2c_flags_pkg::B_BUS_ERR] <= flags_q[i2c_flags_pkg::B_BUS_ERR] && dat_i[8];
         end
         if (wr_dh || line_start || line_stop) begin
            flags_q[i2c_flags_pkg::B_TX_EMPTY] <= 1'b0;
         end
         if (wr_dh || rd_dh) begin
            flags_q[i2c_flags_pkg::B_RX_FULL] <= 1'b0;
         end
         if (armed_q && wr_ctl) begin
            flags_q[i2c_flags_pkg::B_STOP] <= 1'b0;
         end
         if (armed_q && wr_dh) begin
            flags_q[i2c_flags_pkg::B_TEN_BIT] <= 1'b0;
            flags_q[i2c_flags_pkg::B_START] <= 1'b0;
         end
         if ((armed_q && (wr_dh || rd_dh)) || (tx_mode_i && (line_start || line_stop))) begin
            flags_q[i2c_flags_pkg::B_BYTE_DONE] <= 1'b0;
         end
         if (armed_q && rd_st2) begin
            flags_q[i2c_flags_pkg::B_ADDR] <= 1'b0;
         end
         // hardware sets
         if (pec_bad_i) begin
            flags_q[i2c_flags_pkg::B_CHK_ERR] <= 1'b1;
         end
         if (rx_overrun || tx_underrun) begin
            flags_q[i2c_flags_pkg::B_OVERRUN] <= 1'b1;
         end
         if (ack_miss_i) begin
            flags_q[i2c_flags_pkg::B_ACK_FAIL] <= 1'b1;
         end
         if (arb_lost_i) begin
            flags_q[i2c_flags_pkg::B_ARB_LOST] <= 1'b1;
         end
         if (byte_active_i && (line_start || line_stop)) begin
            flags_q[i2c_flags_pkg::B_BUS_ERR] <= 1'b1;
         end
         if (tx_load_i) begin
            flags_q[i2c_flags_pkg::B_TX_EMPTY] <= 1'b1;
         end
         if (byte_rx_i && !rx_stall) begin
            flags_q[i2c_flags_pkg::B_RX_FULL] <= 1'b1;
         end
         if (line_stop && !master_i && slave_acked_q) begin
            flags_q[i2c_flags_pkg::B_STOP] <= 1'b1;
         end
         if (master_i && hdr10_sent_i) begin
            flags_q[i2c_flags_pkg::B_TEN_BIT] <= 1'b1;
         end
         if (!nohold && (tx_stall || rx_stall)) begin
            flags_q[i2c_flags_pkg::B_BYTE_DONE] <= 1'b1;
         end
         if ((master_i && addr_sent_i) || (!master_i && addr_match_i)) begin
            flags_q[i2c_flags_pkg::B_ADDR] <= 1'b1;
         end
         if (start_gen_i) begin
            flags_q[i2c_flags_pkg::B_START] <= 1'b1;
         end
      end
   end

   // =======================================================
   // read data; unlisted status bits and unmapped words read zero, control reads back all 16 written bits
   always_comb begin
      status_one = i2c_flags_pkg::STATUS_RESET;
      status_one[12:6] = flags_q[12:6];
      status_one[4:0] = flags_q[4:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= i2c_flags_pkg::READ_ZERO;
      end else if (acc) begin
         rdat_q <= i2c_flags_pkg::READ_ZERO;
         if (rd_st1) begin
            rdat_q[15:0] <= status_one;
         end else if (rd_dh) begin
            rdat_q[7:0] <= dh_q;
         end else if (!we_i && hit(adr_i, i2c_flags_pkg::OFF_CONTROL_ONE)) begin
            rdat_q[15:0] <= ctl_q;
         end else if (rd_st2) begin
            rdat_q[i2c_flags_pkg::S2_MASTER] <= master_i;
            rdat_q[i2c_flags_pkg::S2_TX] <= tx_mode_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pec_nak_q <= 1'b0;
      end else begin
         pec_nak_q <= pec_bad_i && on;
      end
   end

   assign dat_o = rdat_q;
   assign ack_o = ack_q;
   assign module_on_o = on;
   assign no_clock_hold_o = nohold;
   assign tx_byte_o = dh_q;
   assign hold_clock_o = flags_q[i2c_flags_pkg::B_BYTE_DONE] && !nohold;
   assign pec_nak_o = pec_nak_q;

   // =======================================================
   // checks
   property p_chk_set;
      @(posedge clk_i) disable iff (rst_i) on && pec_bad_i |=> status_one[12] && pec_nak_o;
   endproperty
   a_chk_set: assert property (p_chk_set) else $error("checksum flag or nak missing");

   property p_rx_drop;
      @(posedge clk_i) disable iff (rst_i) on && nohold && rx_stall && !wr_dh |=> status_one[11] && $stable(dh_q);
   endproperty
   a_rx_drop: assert property (p_rx_drop) else $error("overrun did not drop byte");

   property p_tx_resend;
      @(posedge clk_i) disable iff (rst_i) on && tx_underrun && !wr_dh |=> status_one[11] && tx_byte_o == $past(tx_byte_o);
   endproperty
   a_tx_resend: assert property (p_tx_resend) else $error("underrun did not resend");

   property p_w1_keeps;
      @(posedge clk_i) disable iff (rst_i) on && wr_st1 && sel_i[1] && dat_i[10] && status_one[10] |=> status_one[10];
   endproperty
   a_w1_keeps: assert property (p_w1_keeps) else $error("write 1 cleared ack fail");

   property p_w0_clears;
      @(posedge clk_i) disable iff (rst_i) on && wr_st1 && sel_i[1] && !dat_i[9] && !arb_lost_i |=> !status_one[9];
   endproperty
   a_w0_clears: assert property (p_w0_clears) else $error("write 0 kept arbitration flag");

   property p_off_clears;
      @(posedge clk_i) disable iff (rst_i) !on |=> status_one == i2c_flags_pkg::STATUS_RESET;
   endproperty
   a_off_clears: assert property (p_off_clears) else $error("flags survive disable");

   property p_reserved;
      @(posedge clk_i) disable iff (rst_i) ack_o && $past(rd_st1) |-> dat_o[15:13] == 3'h0 && !dat_o[5];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_addr_seq;
      @(posedge clk_i) disable iff (rst_i) rd_st1 ##1 (!acc) [*2] ##1 (rd_st2 && !addr_match_i && !addr_sent_i)
         |=> !status_one[1];
   endproperty
   a_addr_seq: assert property (p_addr_seq) else $error("address flag not cleared");

   property p_start_set;
      @(posedge clk_i) disable iff (rst_i) (on && start_gen_i) ##1 (on && !wr_dh) |-> status_one[0] ##1 status_one[0];
   endproperty
   a_start_set: assert property (p_start_set) else $error("start flag not held");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i) on && !nohold && tx_stall && !wr_ctl |=> hold_clock_o;
   endproperty
   a_hold: assert property (p_hold) else $error("byte done did not hold clock");

   c_overrun: cover property (@(posedge clk_i) disable iff (rst_i) rx_overrun);
   c_slave_stop: cover property (@(posedge clk_i) disable iff (rst_i) line_stop && slave_acked_q && on);
   c_bus_err: cover property (@(posedge clk_i) disable iff (rst_i) on && byte_active_i && line_start);
endmodule

// >>> tb/i2c_bus_peer.sv
// Purpose: other masters and slaves on the two-wire bus, framing start and stop
// Assumes: open-drain lines with pull-ups, so a released line reads high
// Notes: scl stands still high between frames; half link period 200 ns
`timescale 1ns/1ps
module i2c_bus_peer (
   output logic scl_o,
   output logic sda_o
);
   logic scl_pull_q = 1'b0;
   logic sda_pull_q = 1'b0;
   // =======================================================
   // wired-and with pull-up
   assign scl_o = ~scl_pull_q;
   assign sda_o = ~sda_pull_q;
   // =======================================================
   // framing, timed on the link's own clock, not the block's
   task automatic start_cond();
      sda_pull_q = 1'b1;
      #200;
      scl_pull_q = 1'b1;
      #200;
   endtask
   task automatic stop_cond();
      sda_pull_q = 1'b1;
      #200;
      scl_pull_q = 1'b0;
      #200;
      sda_pull_q = 1'b0;
      #200;
   endtask
endmodule

// >>> tb/i2c_status_flags_tb.sv
// Purpose: self-checking bench for the event and error flags over wishbone
// Assumes: ack one cycle after a taken request; flags visible on the next read
// Notes: event pulses are driven directly; the peer frames start and stop
`timescale 1ns/1ps
module i2c_status_flags_tb;
   localparam logic [7:0] A_S1 = i2c_flags_pkg::OFF_STATUS_ONE;
   localparam logic [7:0] A_C1 = i2c_flags_pkg::OFF_CONTROL_ONE;
   localparam logic [7:0] A_DH = i2c_flags_pkg::OFF_DATA_HOLD;
   localparam logic [7:0] A_S2 = i2c_flags_pkg::OFF_STATUS_TWO;
   localparam logic [31:0] ON = 32'h1 << i2c_flags_pkg::C_MODULE_ON;
   localparam logic [31:0] NOHOLD = 32'h1 << i2c_flags_pkg::C_NO_HOLD;
   localparam logic [31:0] M_START = 32'h1 << i2c_flags_pkg::B_START, M_ADDR = 32'h1 << i2c_flags_pkg::B_ADDR;
   localparam logic [31:0] M_BDONE = 32'h1 << i2c_flags_pkg::B_BYTE_DONE, M_TEN = 32'h1 << i2c_flags_pkg::B_TEN_BIT;
   localparam logic [31:0] M_STOP = 32'h1 << i2c_flags_pkg::B_STOP, M_RX = 32'h1 << i2c_flags_pkg::B_RX_FULL;
   localparam logic [31:0] M_TX = 32'h1 << i2c_flags_pkg::B_TX_EMPTY, M_BUS_ERROR_FLAG = 32'h1 << i2c_flags_pkg::B_BUS_ERR;
   localparam logic [31:0] M_ARB = 32'h1 << i2c_flags_pkg::B_ARB_LOST, M_ACKF = 32'h1 << i2c_flags_pkg::B_ACK_FAIL;
   localparam logic [31:0] M_OVER = 32'h1 << i2c_flags_pkg::B_OVERRUN, M_CHK = 32'h1 << i2c_flags_pkg::B_CHK_ERR;
   localparam logic [31:0] M_ERR = M_CHK | M_OVER | M_ACKF | M_ARB | M_BUS_ERROR_FLAG;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   localparam int E_START = 0, E_ASENT = 1, E_HDR = 2, E_AMATCH = 3, E_LOAD = 4;
   localparam int E_TXD = 5, E_RX = 6, E_ACKM = 7, E_ARB = 8, E_PEC = 9;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack_o, scl, sda, module_on_o, no_clock_hold_o, hold_clock_o, pec_nak_o;
   logic master_i = 1'b0, tx_mode_i = 1'b0, byte_active_i = 1'b0;
   logic [9:0] ev = 10'h000;
   logic [7:0] rx_byte_i = 8'h00;
   logic [7:0] tx_byte_o;
   int n_mismatch = 0;
   int n_tests = 0;
   always #25 clk_i = ~clk_i;
   i2c_bus_peer peer (.scl_o(scl), .sda_o(sda));
   i2c_status_flags dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl), .sda_i(sda),
      .master_i(master_i), .tx_mode_i(tx_mode_i), .byte_active_i(byte_active_i),
      .start_gen_i(ev[E_START]), .addr_sent_i(ev[E_ASENT]), .hdr10_sent_i(ev[E_HDR]),
      .addr_match_i(ev[E_AMATCH]), .tx_load_i(ev[E_LOAD]), .byte_tx_done_i(ev[E_TXD]),
      .byte_rx_i(ev[E_RX]), .rx_byte_i(rx_byte_i), .ack_miss_i(ev[E_ACKM]), .arb_lost_i(ev[E_ARB]),
      .pec_bad_i(ev[E_PEC]), .module_on_o(module_on_o), .no_clock_hold_o(no_clock_hold_o),
      .tx_byte_o(tx_byte_o), .hold_clock_o(hold_clock_o), .pec_nak_o(pec_nak_o)
   );
   // =======================================================
   // reporting
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // =======================================================
   // wishbone classic single cycle; ack sampled at the rising edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= wd;
      // no local limit: only the watchdog ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] rd;
      wb(1'b1, a, wd, rd);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] rd;
      wb(1'b0, a, 32'h0000_0000, rd);
      chk(nm, rd & m, e);
   endtask
   // one-cycle event pulse from the byte engine
   task automatic pulse(input int i);
      @(posedge clk_i);
      ev[i] <= 1'b1;
      @(posedge clk_i);
      ev[i] <= 1'b0;
   endtask
   // =======================================================
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      results();
   end
   // =======================================================
   // tests
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk("status_reset", A_S1, ALL, 32'h0);
      rd_chk("unmapped", 8'h20, ALL, 32'h0);
      wr(A_C1, ON);
      chk("module_on", 32'(module_on_o), 32'h1);
      pulse(E_PEC);
      @(posedge clk_i);
      chk("pec_nak", 32'(pec_nak_o), 32'h1);
      pulse(E_ACKM);
      pulse(E_ARB);
      wr(A_S1, 32'hFFFF);
      rd_chk("errors_write1", A_S1, ALL, M_CHK | M_ACKF | M_ARB);
      wr(A_S1, ~M_ACKF & 32'hFFFF);
      rd_chk("ackfail_clear", A_S1, M_ERR, M_CHK | M_ARB);
      wr(A_S1, 32'h0);
      rd_chk("errors_clear", A_S1, M_ERR, 32'h0);
      byte_active_i <= 1'b1;
      peer.start_cond();
      repeat (10) @(posedge clk_i);
      rd_chk("bus_error", A_S1, M_BUS_ERROR_FLAG, M_BUS_ERROR_FLAG);
      peer.stop_cond();
      repeat (10) @(posedge clk_i);
      byte_active_i <= 1'b0;
      pulse(E_LOAD);
      rd_chk("tx_empty_set", A_S1, M_TX, M_TX);
      wr(A_DH, 32'hA5);
      rd_chk("tx_empty_write", A_S1, M_TX, 32'h0);
      pulse(E_LOAD);
      wr(A_C1, ON | NOHOLD);
      chk("no_clock_hold", 32'(no_clock_hold_o), 32'h1);
      pulse(E_TXD);
      rd_chk("underrun", A_S1, M_OVER | M_BDONE, M_OVER);
      chk("resend", 32'(tx_byte_o), 32'hA5);
      wr(A_C1, ON);
      wr(A_S1, 32'h0);
      pulse(E_TXD);
      rd_chk("byte_done_tx", A_S1, M_BDONE | M_OVER, M_BDONE);
      chk("hold_clock", 32'(hold_clock_o), 32'h1);
      wr(A_DH, 32'h5A);
      rd_chk("byte_done_write", A_S1, M_BDONE | M_TX, 32'h0);
      tx_mode_i <= 1'b1;
      pulse(E_LOAD);
      pulse(E_TXD);
      peer.start_cond();
      repeat (10) @(posedge clk_i);
      rd_chk("byte_done_start", A_S1, M_BDONE | M_TX, 32'h0);
      peer.stop_cond();
      repeat (10) @(posedge clk_i);
      tx_mode_i <= 1'b0;
      rx_byte_i <= 8'h3C;
      pulse(E_RX);
      rd_chk("rx_full", A_S1, M_RX, M_RX);
      rx_byte_i <= 8'h99;
      pulse(E_RX);
      rd_chk("byte_done_rx", A_S1, M_BDONE | M_OVER, M_BDONE);
      rd_chk("rx_kept", A_DH, 32'hFF, 32'h3C);
      rd_chk("rx_read_clear", A_S1, M_BDONE | M_RX, 32'h0);
      rx_byte_i <= 8'h11;
      pulse(E_RX);
      wr(A_C1, ON | NOHOLD);
      rx_byte_i <= 8'h22;
      pulse(E_RX);
      rd_chk("overrun", A_S1, M_OVER | M_BDONE, M_OVER);
      rd_chk("rx_dropped", A_DH, 32'hFF, 32'h11);
      wr(A_C1, ON);
      wr(A_S1, 32'h0);
      master_i <= 1'b1;
      pulse(E_START);
      pulse(E_HDR);
      rd_chk("start_ten", A_S1, M_START | M_TEN, M_START | M_TEN);
      rd_chk("control_read", A_C1, 32'hFF, ON);
      wr(A_DH, 32'h0F);
      rd_chk("unarmed_keep", A_S1, M_START | M_TEN, M_START | M_TEN);
      wr(A_DH, 32'hF0);
      rd_chk("start_ten_clear", A_S1, M_START | M_TEN, 32'h0);
      master_i <= 1'b1;
      pulse(E_ASENT);
      rd_chk("addr_master", A_S1, M_ADDR, M_ADDR);
      rd_chk("status_two", A_S2, ALL, 32'h1 << i2c_flags_pkg::S2_MASTER);
      rd_chk("addr_clear", A_S1, M_ADDR, 32'h0);
      master_i <= 1'b0;
      peer.start_cond();
      pulse(E_AMATCH);
      rd_chk("addr_slave", A_S1, M_ADDR, M_ADDR);
      peer.stop_cond();
      repeat (10) @(posedge clk_i);
      rd_chk("stop_seen", A_S1, M_STOP | M_BUS_ERROR_FLAG, M_STOP);
      wr(A_C1, ON);
      rd_chk("stop_clear", A_S1, M_STOP, 32'h0);
      pulse(E_ARB);
      pulse(E_LOAD);
      wr(A_C1, 32'h0);
      chk("module_off", 32'(module_on_o), 32'h0);
      rd_chk("disable_clear", A_S1, ALL, 32'h0);
      pulse(E_ACKM);
      rd_chk("off_hold", A_S1, ALL, 32'h0);
      results();
   end
endmodule
